// ### logic/qac_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - frame low starts conversion, high ends frame
// - track during first three shift clocks
// - hold, convert, result MSB first from fifth
// - output driven only while frame low
// - power down when frame high or between
// - back-to-back conversions restart track after sixteen
// - shift clock ignored while frame high
// - frame fall with clock low counts falling
// - frame fall with clock high waits
// - command captured on first eight rising edges
// - channel written now used next conversion
// - first conversion after reset uses channel zero
// - bits five to three form channel field
// - other command bits have no effect
// - top field bit ignored, low two decode
// - result is unsigned straight binary code
// - sample held at fourth falling edge
// - nap from sixteenth fall until next first
module qac_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic frame_select_n,
    input wire logic shift_clock,
    input wire logic serial_command_in,
    input wire logic [7:0] analog_ch0,
    input wire logic [7:0] analog_ch1,
    input wire logic [7:0] analog_ch2,
    input wire logic [7:0] analog_ch3,
    output logic serial_result_out,
    output logic serial_result_oe,
    output logic track_mode,
    output logic power_down,
    output logic [1:0] active_chan
);

    logic cs_s;
    logic sclk_s;
    logic din_s;
    logic cs_prev_q;
    logic sclk_prev_q;
    logic frame_on;
    logic frame_fall;
    logic int_fall;
    logic int_rise;
    logic [4:0] fall_q;
    logic [4:0] fall_d;
    logic [4:0] rise_q;
    logic conv_start;
    qac_pkg::qac_state_t st_q;
    qac_pkg::qac_state_t st_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_word;
    logic [1:0] next_chan_q;
    logic [7:0] picked;
    logic [7:0] res_q;

    // pin synchronisers
    qac_sync #(.RESET_VAL(1'b1)) u_sync_cs (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(frame_select_n),
        .sync_out(cs_s)
    );
    qac_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(shift_clock),
        .sync_out(sclk_s)
    );
    qac_sync #(.RESET_VAL(1'b0)) u_sync_din (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(serial_command_in),
        .sync_out(din_s)
    );

    // edge history of synchronised pins
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            cs_prev_q <= cs_s;
            sclk_prev_q <= sclk_s;
        end
    end

    // internal clock edges, gated by frame
    assign frame_on = !cs_s;
    assign frame_fall = cs_prev_q && !cs_s;
    assign int_fall = frame_on
        && ((sclk_prev_q && !sclk_s) || (frame_fall && !sclk_s));
    assign int_rise = frame_on && !sclk_prev_q && sclk_s
        && (st_q != qac_pkg::QAC_OFF);
    assign conv_start = int_fall
        && ((st_q == qac_pkg::QAC_OFF) || (fall_q == qac_pkg::CONV_CLOCKS));

    // next falling count
    always_comb
    begin
        fall_d = fall_q;
        if (!frame_on)
        begin
            fall_d = 5'h00;
        end
        else if (conv_start)
        begin
            fall_d = qac_pkg::FIRST_FALL;
        end
        else if (int_fall && fall_q < qac_pkg::CONV_CLOCKS)
        begin
            fall_d = fall_q + 5'h01;
        end
    end

    // next sequencing state
    always_comb
    begin
        st_d = st_q;
        if (!frame_on)
        begin
            st_d = qac_pkg::QAC_OFF;
        end
        else if (int_fall)
        begin
            unique case (fall_d)
                qac_pkg::FIRST_FALL: st_d = qac_pkg::QAC_TRACK;
                qac_pkg::HOLD_FALL: st_d = qac_pkg::QAC_HOLD;
                qac_pkg::CONV_CLOCKS: st_d = qac_pkg::QAC_NAP;
                default: st_d = st_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q <= qac_pkg::QAC_OFF;
            fall_q <= 5'h00;
            track_mode <= 1'b0;
            power_down <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            fall_q <= fall_d;
            track_mode <= (st_d == qac_pkg::QAC_TRACK);
            power_down <= (st_d == qac_pkg::QAC_OFF)
                || (st_d == qac_pkg::QAC_NAP);
        end
    end

    // rising edge count per conversion
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !frame_on || conv_start)
        begin
            rise_q <= 5'h00;
        end
        else if (int_rise && rise_q < qac_pkg::CONV_CLOCKS)
        begin
            rise_q <= rise_q + 5'h01;
        end
    end

    assign cmd_word = {cmd_q[6:0], din_s};
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cmd_q <= qac_pkg::RESET_CMD;
        end
        else if (int_rise && rise_q < qac_pkg::CMD_RISES)
        begin
            cmd_q <= cmd_word;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            next_chan_q <= qac_pkg::RESET_CHAN;
        end
        else if (int_rise && rise_q == qac_pkg::CMD_RISES - 5'h01)
        begin
            next_chan_q <= cmd_word[qac_pkg::CHAN_LSB_POS +: 2];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            active_chan <= qac_pkg::RESET_CHAN;
        end
        else if (conv_start)
        begin
            active_chan <= next_chan_q;
        end
    end

    always_comb
    begin
        unique case (active_chan)
            2'h0: picked = analog_ch0;
            2'h1: picked = analog_ch1;
            2'h2: picked = analog_ch2;
            2'h3: picked = analog_ch3;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !frame_on)
        begin
            res_q <= qac_pkg::RESET_RES;
            serial_result_out <= 1'b0;
        end
        else if (int_fall)
        begin
            if (fall_d == qac_pkg::HOLD_FALL)
            begin
                res_q <= picked;
            end
            else
            begin
                res_q <= {res_q[6:0], 1'b0};
            end
            // bits go out on falls five to twelve, low otherwise
            serial_result_out <= (fall_d > qac_pkg::HOLD_FALL)
                && (fall_d <= qac_pkg::LAST_DATA_FALL) && res_q[7];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            serial_result_oe <= 1'b0;
        end
        else
        begin
            serial_result_oe <= frame_on;
        end
    end

    // checks on sequencing
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_start_track;
        (st_q == qac_pkg::QAC_OFF) && int_fall |=> track_mode && fall_q == 1;
    endproperty
    a_start_track: assert property (p_start_track)
        else $error("conversion did not start in track");

    property p_track_span;
        track_mode |-> fall_q >= 1 && fall_q <= 3;
    endproperty
    a_track_span: assert property (p_track_span)
        else $error("track outside first three clocks");

    property p_hold_fourth;
        int_fall && fall_q == 3 |=> st_q == qac_pkg::QAC_HOLD && !track_mode
            && res_q == $past(picked);
    endproperty
    a_hold_fourth: assert property (p_hold_fourth)
        else $error("no hold at fourth falling edge");

    property p_oe_off;
        cs_s ##1 cs_s |-> ##1 !serial_result_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("output enabled outside frame");

    property p_pd_frame;
        cs_s |=> power_down && fall_q == 0 && rise_q == 0;
    endproperty
    a_pd_frame: assert property (p_pd_frame)
        else $error("not powered down outside frame");

    property p_nap;
        int_fall && fall_q == 15 |=> power_down ##0 !track_mode;
    endproperty
    a_nap: assert property (p_nap)
        else $error("no nap after sixteenth fall");

    property p_restart;
        int_fall && fall_q == 16 |=> track_mode && !power_down;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no restart of track mode");

    property p_cs_low_clock;
        frame_fall && !sclk_s && st_q == qac_pkg::QAC_OFF |=> track_mode;
    endproperty
    a_cs_low_clock: assert property (p_cs_low_clock)
        else $error("frame fall not seen as clock fall");

    property p_cs_high_clock;
        frame_fall && sclk_s |=> !track_mode;
    endproperty
    a_cs_high_clock: assert property (p_cs_high_clock)
        else $error("track entered without clock fall");

    property p_chan_latch;
        int_rise && rise_q == 7 |=> next_chan_q == $past(cmd_q[3:2]);
    endproperty
    a_chan_latch: assert property (p_chan_latch)
        else $error("channel field not latched");

    property p_chan_pipe;
        conv_start |=> active_chan == $past(next_chan_q);
    endproperty
    a_chan_pipe: assert property (p_chan_pipe)
        else $error("channel not taken from last word");

    property p_msb_first;
        int_fall && fall_q == 4 |=> serial_result_out == $past(res_q[7]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("msb not driven at fifth fall");

    property p_quiet;
        (fall_q >= 13 || (fall_q >= 1 && fall_q <= 4)) |-> !serial_result_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("output not low outside result");

    c_frame: cover property (frame_fall ##[1:200] track_mode);
    c_hold: cover property (st_q == qac_pkg::QAC_HOLD);
    c_back2back: cover property (int_fall && fall_q == 16);
    c_chan3: cover property (conv_start && next_chan_q == 2'h3);

endmodule
`default_nettype wire

// ### logic/qac_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for pin inputs
module qac_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ### shared/qac_pkg.sv
package qac_pkg;

    // serial word, result, channel and counter widths
    localparam int unsigned CMD_W = 8;
    localparam int unsigned RES_W = 8;
    localparam int unsigned CHAN_W = 2;
    localparam int unsigned CNT_W = 5;

    // clock positions within one conversion
    localparam logic [4:0] CONV_CLOCKS = 5'h10;
    localparam logic [4:0] FIRST_FALL = 5'h01;
    localparam logic [4:0] LAST_TRACK_FALL = 5'h03;
    localparam logic [4:0] HOLD_FALL = 5'h04;
    localparam logic [4:0] LAST_DATA_FALL = 5'h0C;
    localparam logic [4:0] CMD_RISES = 5'h08;

    // control word field layout
    localparam int unsigned CHAN_MSB_POS = 5;
    localparam int unsigned CHAN_LSB_POS = 3;

    // reset values
    localparam logic [1:0] RESET_CHAN = 2'h0;
    localparam logic [7:0] RESET_CMD = 8'h00;
    localparam logic [7:0] RESET_RES = 8'h00;

    // conversion sequencing states
    typedef enum logic [1:0] {
        QAC_OFF,
        QAC_TRACK,
        QAC_HOLD,
        QAC_NAP
    } qac_state_t;

endpackage

// ### verif/qac_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[FAIL] %0t %s", $time, msg); \
        end \
    end
module qac_ctrl_bench;
    logic sys_clk;
    logic rst_n;
    logic frame_select_n;
    logic shift_clock;
    logic serial_command_in;
    logic serial_result_out;
    logic serial_result_oe;
    logic track_mode;
    logic power_down;
    logic [1:0] active_chan;
    logic [7:0] code [4] = '{8'h01, 8'hFE, 8'hA5, 8'h5A};
    logic [15:0] res, trk, pd, oe;
    logic [1:0] exp_chan;
    int checks = 0;
    int miscompares = 0;
    // conversion table: command, frame opening, frame closing
    logic [7:0] cmds [6] = '{8'hFF, 8'h08, 8'h10, 8'h20, 8'hC7, 8'h18};
    int opens [6] = '{1, 0, 2, 1, 0, 0};
    int wig [6] = '{-1, 5, 0, -1, -1, 3};

    qac_ctrl i_dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .frame_select_n(frame_select_n),
        .shift_clock(shift_clock),
        .serial_command_in(serial_command_in),
        .analog_ch0(code[0]),
        .analog_ch1(code[1]),
        .analog_ch2(code[2]),
        .analog_ch3(code[3]),
        .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe),
        .track_mode(track_mode),
        .power_down(power_down),
        .active_chan(active_chan)
    );

    qac_host i_host (
        .sys_clk(sys_clk),
        .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe),
        .track_mode(track_mode),
        .power_down(power_down),
        .frame_select_n(frame_select_n),
        .shift_clock(shift_clock),
        .serial_command_in(serial_command_in)
    );

    // 50 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // verdict and end of run
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #100000;
        miscompares++;
        test_done();
    end

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        #100;
        `CHK({serial_result_oe, serial_result_out, power_down, track_mode,
              active_chan}, 6'b001000, "reset state")
        exp_chan = 2'h0;
        for (int i = 0; i < 6; i++)
        begin
            if (opens[i] > 0)
                i_host.open_frame(opens[i] == 2);
            i_host.convert(cmds[i], res, trk, pd, oe);
            `CHK(res, {4'b0000, code[exp_chan], 4'b0000}, "result")
            `CHK(trk, 16'hE000, "track span")
            `CHK(pd, 16'h0001, "nap span")
            `CHK(oe, 16'hFFFF, "enable in frame")
            `CHK(active_chan, exp_chan, "channel")
            if (opens[i] == 0)
                `CHK(trk[15:12], 4'b1110, "retrack")
            exp_chan = cmds[i][4:3];
            if (wig[i] >= 0)
            begin
                i_host.close_frame(wig[i]);
                `CHK({serial_result_oe, serial_result_out, power_down,
                      track_mode}, 4'b0010, "idle")
            end
            $display("conversion %0d done", i);
        end
        test_done();
    end
endmodule
`default_nettype wire

// ### verif/qac_host.sv
`timescale 1ns/10ps
`default_nettype none
// host serial port model: frames, shift clock, command bits
module qac_host (
    input wire logic sys_clk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic track_mode,
    input wire logic power_down,
    output logic frame_select_n,
    output logic shift_clock,
    output logic serial_command_in
);
    // idle pins before the first frame
    initial
    begin
        frame_select_n = 1'b1;
        shift_clock = 1'b0;
        serial_command_in = 1'b0;
    end

    task automatic open_frame(input logic rest_high);
        @(posedge sys_clk);
        #1 shift_clock = rest_high;
        #160 frame_select_n = 1'b0;
        if (rest_high)
            #80;
    endtask

    // command on rises one to eight
    task automatic convert(input logic [7:0] cmd, output logic [15:0] res,
                           output logic [15:0] trk, output logic [15:0] pd,
                           output logic [15:0] oe);
        for (int k = 1; k <= 16; k++)
        begin
            shift_clock = 1'b0;
            serial_command_in = (k <= 8) ? cmd[8 - k] : ~serial_command_in;
            #80 shift_clock = 1'b1;
            #70;
            // sample late in the high phase, bit stands until next fall
            res[16 - k] = serial_result_out;
            trk[16 - k] = track_mode;
            pd[16 - k] = power_down;
            oe[16 - k] = serial_result_oe;
            #10;
        end
    endtask

    task automatic close_frame(input int wiggles);
        frame_select_n = 1'b1;
        serial_command_in = ~serial_command_in; // released line, not held
        repeat (wiggles)
        begin
            #80 shift_clock = ~shift_clock;
        end
        #160;
    endtask
endmodule
`default_nettype wire
